// ---- commutation_timing_pkg.sv ----
package commutation_timing_pkg;

  // register access
  localparam int          ADDR_W             = 6;
  localparam int          DATA_W             = 8;
  localparam logic [5:0]  PHASE_ADV_OFFSET   = 6'h0B;
  localparam logic [5:0]  DELAY_COMP_OFFSET  = 6'h0C;
  localparam logic [7:0]  PHASE_ADV_RESET    = 8'h00;
  localparam logic [7:0]  DELAY_COMP_RESET   = 8'h00;

  // field positions
  localparam int          ADV_LEVEL_LSB      = 0;
  localparam int          ADV_LEVEL_W        = 3;
  localparam int          TARGET_SEL_LSB     = 0;
  localparam int          TARGET_SEL_W       = 4;
  localparam int          COMP_ENABLE_BIT    = 4;

  // timing
  localparam int          CLK_PERIOD_NS      = 100;
  localparam int          DELAY_FIRST_NS     = 400;
  localparam int          DELAY_STEP_NS      = 200;
  localparam int          DELAY_CYC_W        = 6;
  localparam int          DEG_W              = 5;
  localparam int          PHASES             = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] wr_data;
  } reg_req_type;

  typedef struct packed {
    logic [ADV_LEVEL_W-1:0]                  phase_advance_level;
    logic                                    delay_comp_enable;
    logic [TARGET_SEL_W-1:0]                 target_delay_select;
    logic [DEG_W-1:0]                        advance_deg;
    logic [DELAY_CYC_W-1:0]                  target_cycles;
    logic [DATA_W-1:0]                       rd_data;
    logic [PHASES-1:0]                       in_last;
    logic [PHASES-1:0]                       pend;
    logic [PHASES-1:0]                       pend_val;
    logic [PHASES-1:0][DELAY_CYC_W-1:0]      cnt;
    logic [PHASES-1:0]                       phase_out;
  } state_type;

endpackage

// ---- commutation_timing_config_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module commutation_timing_config_regs (
  // clock and reset
  input  wire logic                                            sys_clk,
  input  wire logic                                            reset,
  input  wire logic                                            ce,
  // register access from the serial port decoder
  input  wire commutation_timing_pkg::reg_req_type             req,
  output logic [commutation_timing_pkg::DATA_W-1:0]            rd_data,
  // configuration outputs
  output logic [commutation_timing_pkg::ADV_LEVEL_W-1:0]       phase_advance_level,
  output logic [commutation_timing_pkg::DEG_W-1:0]             advance_deg,
  output logic                                                 delay_comp_enable,
  output logic [commutation_timing_pkg::TARGET_SEL_W-1:0]      target_delay_select,
  output logic [commutation_timing_pkg::DELAY_CYC_W-1:0]       target_cycles,
  // phase timing path
  input  wire logic [commutation_timing_pkg::PHASES-1:0]       phase_in,
  input  wire logic [commutation_timing_pkg::DELAY_CYC_W-1:0]  intrinsic_cycles,
  output logic [commutation_timing_pkg::PHASES-1:0]            phase_out
);

  localparam int CYC_W   = commutation_timing_pkg::DELAY_CYC_W;
  localparam int ADV_LSB = commutation_timing_pkg::ADV_LEVEL_LSB;
  localparam int ADV_W   = commutation_timing_pkg::ADV_LEVEL_W;
  localparam int TGT_LSB = commutation_timing_pkg::TARGET_SEL_LSB;
  localparam int TGT_W   = commutation_timing_pkg::TARGET_SEL_W;
  localparam int EN_BIT  = commutation_timing_pkg::COMP_ENABLE_BIT;

  // the decode tables and read muxes are written for these sizes only
  initial begin
    if (commutation_timing_pkg::DELAY_STEP_NS %
        commutation_timing_pkg::CLK_PERIOD_NS != 0)
      $error("delay step is not a whole number of clock cycles");
    if (commutation_timing_pkg::DELAY_FIRST_NS %
        commutation_timing_pkg::CLK_PERIOD_NS != 0)
      $error("first delay is not a whole number of clock cycles");
    if (ADV_W != 3 ||
        TGT_W != 4 ||
        commutation_timing_pkg::DATA_W != 8)
      $error("field widths do not match the decode tables");
    if ((commutation_timing_pkg::DELAY_FIRST_NS +
         ((1 << TGT_W) - 2) * commutation_timing_pkg::DELAY_STEP_NS) /
        commutation_timing_pkg::CLK_PERIOD_NS >= (1 << CYC_W))
      $error("longest target delay does not fit the cycle counter");
  end

  function automatic logic [commutation_timing_pkg::DEG_W-1:0] deg_of(
    input logic [2:0] lvl);
    case (lvl)
      3'h0: deg_of = 5'h00;
      3'h1: deg_of = 5'h04;
      3'h2: deg_of = 5'h07;
      3'h3: deg_of = 5'h0B;
      3'h4: deg_of = 5'h0F;
      3'h5: deg_of = 5'h14;
      3'h6: deg_of = 5'h19;
      default: deg_of = 5'h1E;
    endcase
  endfunction

  function automatic logic [CYC_W-1:0] cycles_of(input logic [3:0] code);
    int ns;
    ns = 0;
    if (code != 4'h0)
      ns = commutation_timing_pkg::DELAY_FIRST_NS +
           (int'(code) - 1) * commutation_timing_pkg::DELAY_STEP_NS;
    cycles_of = CYC_W'(ns / commutation_timing_pkg::CLK_PERIOD_NS);
  endfunction

  commutation_timing_pkg::state_type s_q;
  commutation_timing_pkg::state_type s_d;

  always_comb begin
    logic [CYC_W-1:0] var_cyc;
    var_cyc = '0;
    s_d = s_q;
    // writes: reserved bits are never stored
    if (req.wr_en && req.addr == commutation_timing_pkg::PHASE_ADV_OFFSET) begin
      s_d.phase_advance_level = req.wr_data[ADV_LSB +: ADV_W];
    end else if (req.wr_en &&
                 req.addr == commutation_timing_pkg::DELAY_COMP_OFFSET) begin
      s_d.delay_comp_enable   = req.wr_data[EN_BIT];
      s_d.target_delay_select = req.wr_data[TGT_LSB +: TGT_W];
    end
    s_d.advance_deg   = deg_of(s_d.phase_advance_level);
    s_d.target_cycles = cycles_of(s_d.target_delay_select);
    // reads: unmapped addresses return zero
    if (req.rd_en && req.addr == commutation_timing_pkg::PHASE_ADV_OFFSET) begin
      s_d.rd_data = {5'h00, s_q.phase_advance_level};
    end else if (req.rd_en &&
                 req.addr == commutation_timing_pkg::DELAY_COMP_OFFSET) begin
      s_d.rd_data = {3'h0, s_q.delay_comp_enable,
                     s_q.target_delay_select};
    end else if (req.rd_en) begin
      s_d.rd_data = 8'h00;
    end
    // added delay is target minus what the driver already spends
    if (s_q.target_cycles > intrinsic_cycles)
      var_cyc = s_q.target_cycles - intrinsic_cycles;
    for (int p = 0; p < commutation_timing_pkg::PHASES; p++) begin
      s_d.in_last[p] = phase_in[p];
      if (!s_q.delay_comp_enable) begin
        // bypass also drops any edge still waiting
        s_d.phase_out[p] = phase_in[p];
        s_d.pend[p]      = 1'b0;
        s_d.cnt[p]       = '0;
      end else if (phase_in[p] != s_q.in_last[p]) begin
        // a new edge restarts the wait; an edge shorter than the wait is lost
        if (var_cyc == '0) begin
          s_d.phase_out[p] = phase_in[p];
          s_d.pend[p]      = 1'b0;
        end else begin
          s_d.pend[p]     = 1'b1;
          s_d.pend_val[p] = phase_in[p];
          s_d.cnt[p]      = var_cyc;
        end
      end else if (s_q.pend[p]) begin
        if (s_q.cnt[p] == CYC_W'(1)) begin
          s_d.phase_out[p] = s_q.pend_val[p];
          s_d.pend[p]      = 1'b0;
        end
        s_d.cnt[p] = s_q.cnt[p] - CYC_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rd_data             = s_q.rd_data;
  assign phase_advance_level = s_q.phase_advance_level;
  assign advance_deg         = s_q.advance_deg;
  assign delay_comp_enable   = s_q.delay_comp_enable;
  assign target_delay_select = s_q.target_delay_select;
  assign target_cycles       = s_q.target_cycles;
  assign phase_out           = s_q.phase_out;

  a_adv_write_store: assert property (@(posedge sys_clk) disable iff (reset)
    ce && req.wr_en && req.addr == commutation_timing_pkg::PHASE_ADV_OFFSET
    |=> phase_advance_level == $past(req.wr_data[2:0]))
    else $error("advance level not stored");

  a_adv_deg_map: assert property (@(posedge sys_clk) disable iff (reset)
    advance_deg == deg_of(phase_advance_level))
    else $error("advance degrees do not match level");

  a_comp_en_store: assert property (@(posedge sys_clk) disable iff (reset)
    ce && req.wr_en && req.addr == commutation_timing_pkg::DELAY_COMP_OFFSET
    |=> delay_comp_enable == $past(req.wr_data[4]))
    else $error("compensation enable not stored");

  a_target_cyc_map: assert property (@(posedge sys_clk) disable iff (reset)
    target_cycles == cycles_of(target_delay_select))
    else $error("target cycles do not match code");

  a_rsv_read_zero: assert property (@(posedge sys_clk) disable iff (reset)
    ce && req.rd_en && req.addr == commutation_timing_pkg::DELAY_COMP_OFFSET
    |=> rd_data[7:5] == 3'h0 && rd_data[4] == $past(delay_comp_enable))
    else $error("delay register read wrong");

  a_reset_clears: assert property (@(posedge sys_clk)
    reset |=> rd_data == 8'h00 && phase_advance_level == 3'h0
              && !delay_comp_enable)
    else $error("reset values wrong");

  a_bypass_follow: assert property (@(posedge sys_clk) disable iff (reset)
    ce && !delay_comp_enable |=> phase_out == $past(phase_in))
    else $error("bypass does not follow input");

  // a fresh edge restarts the wait, so the count, not the time, is bounded
  a_pend_bounded: assert property (@(posedge sys_clk)
    disable iff (reset || !ce)
    s_q.pend[0] |-> s_q.cnt[0] != 6'h00 && s_q.cnt[0] <= 6'h20)
    else $error("waiting edge count out of range");

  a_pend_release: assert property (@(posedge sys_clk)
    disable iff (reset || !ce)
    delay_comp_enable && s_q.pend[0] && s_q.cnt[0] == CYC_W'(1)
    && phase_in[0] == s_q.in_last[0]
    |=> phase_out[0] == $past(s_q.pend_val[0]) && !s_q.pend[0])
    else $error("waiting edge not released on time");

  a_edge_loads: assert property (@(posedge sys_clk)
    disable iff (reset || !ce)
    delay_comp_enable && phase_in[0] != s_q.in_last[0]
    && target_cycles > intrinsic_cycles
    |=> s_q.pend[0] && s_q.cnt[0] == $past(target_cycles - intrinsic_cycles))
    else $error("edge did not load the added wait");

  a_bypass_clears: assert property (@(posedge sys_clk)
    disable iff (reset)
    ce && !delay_comp_enable |=> s_q.pend == 3'h0)
    else $error("bypass left an edge waiting");

  a_adv_rsv_read: assert property (@(posedge sys_clk)
    disable iff (reset)
    ce && req.rd_en && req.addr == commutation_timing_pkg::PHASE_ADV_OFFSET
    |=> rd_data[7:3] == 5'h00 && rd_data[2:0] == $past(phase_advance_level))
    else $error("advance register read wrong");

  a_target_store: assert property (@(posedge sys_clk)
    disable iff (reset)
    ce && req.wr_en && req.addr == commutation_timing_pkg::DELAY_COMP_OFFSET
    |=> target_delay_select == $past(req.wr_data[3:0]))
    else $error("target code not stored");

  // larger codes must never give a shorter angle or delay
  a_deg_rising: assert property (@(posedge sys_clk)
    disable iff (reset)
    phase_advance_level > $past(phase_advance_level)
    |-> advance_deg > $past(advance_deg))
    else $error("advance degrees not rising with level");

  a_delay_rising: assert property (@(posedge sys_clk)
    disable iff (reset)
    target_delay_select > $past(target_delay_select)
    |-> target_cycles > $past(target_cycles))
    else $error("target cycles not rising with code");

endmodule // commutation_timing_config_regs
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input  wire logic                              sys_clk,
  // register port
  output var commutation_timing_pkg::reg_req_type req,
  input  wire logic [7:0]                        rd_data
);
  initial req = '0;
  // the strobe drops on the accepting edge, so the next call starts later
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{a, 1'b1, 1'b0, d};
    @(posedge sys_clk);
    req.wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge sys_clk);
    req.rd_en <= 1'b0;
    @(negedge sys_clk);
    d = rd_data;
  endtask
endmodule // host_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb;
  logic sys_clk = 1'b0, reset = 1'b1, ce = 1'b1;
  commutation_timing_pkg::reg_req_type req;
  logic [7:0] rd_data, v;
  logic [2:0] phase_advance_level, phase_out, phase_in = 3'h0;
  logic [4:0] advance_deg;
  logic       delay_comp_enable;
  logic [3:0] target_delay_select;
  logic [5:0] target_cycles, intrinsic_cycles = 6'h00, e;
  logic [4:0] deg [8] = '{5'h00, 5'h04, 5'h07, 5'h0B, 5'h0F, 5'h14, 5'h19,
                          5'h1E};
  int error_cnt = 0, n_checks = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  host_model host (.sys_clk, .req, .rd_data);
  commutation_timing_config_regs i_commutation_timing_config_regs (
    .sys_clk, .reset, .ce, .req, .rd_data, .phase_advance_level,
    .advance_deg, .delay_comp_enable, .target_delay_select, .target_cycles,
    .phase_in, .intrinsic_cycles, .phase_out);
  task complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang is cut short at 5000 cycles, well above the roughly 150 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin error_cnt++; complete_run(); end
  end
  task reset_values;
    host.rd(6'h0B, v); `CHK("adv reg", 8'h00, v)
    host.rd(6'h0C, v); `CHK("dly reg", 8'h00, v)
    `CHK("enable", 1'b0, delay_comp_enable)
    `CHK("adv lvl", 3'h0, phase_advance_level)
    `CHK("adv deg", 5'h00, advance_deg)
    `CHK("tgt sel", 4'h0, target_delay_select)
    `CHK("tgt cyc", 6'h00, target_cycles)
  endtask
  task adv_levels;
    for (int i = 0; i < 8; i++) begin
      host.wr(6'h0B, {5'h1F, 3'(i)});
      host.rd(6'h0B, v); `CHK("adv reg", {5'h00, 3'(i)}, v)
      `CHK("adv deg", deg[i], advance_deg)
      `CHK("adv lvl", 3'(i), phase_advance_level)
    end
  endtask
  task targets;
    for (int i = 0; i < 16; i++) begin
      host.wr(6'h0C, {3'h7, 1'b1, 4'(i)});
      e = (i == 0) ? 6'h00 : 6'(2 * i + 2);
      host.rd(6'h0C, v); `CHK("dly reg", {3'h0, 1'b1, 4'(i)}, v)
      `CHK("tgt cyc", e, target_cycles)
      `CHK("tgt sel", 4'(i), target_delay_select)
      `CHK("enable", 1'b1, delay_comp_enable)
    end
    host.wr(6'h0C, 8'h0F);
    @(negedge sys_clk);
    `CHK("enable", 1'b0, delay_comp_enable)
  endtask
  task unmapped;
    host.wr(6'h0D, 8'hFF);
    host.rd(6'h0D, v); `CHK("unmapped", 8'h00, v)
    host.rd(6'h0B, v); `CHK("adv reg", 8'h07, v)
    host.rd(6'h0C, v); `CHK("dly reg", 8'h0F, v)
  endtask
  // target 4 cycles less 1 intrinsic leaves 3 cycles of added wait
  task phase_delay;
    host.wr(6'h0C, 8'h11);
    @(posedge sys_clk) intrinsic_cycles <= 6'h01;
    @(posedge sys_clk) phase_in <= 3'h7;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk); `CHK("phase early", 3'h0, phase_out)
    @(negedge sys_clk); `CHK("phase late", 3'h7, phase_out)
    // driver already as slow as the target: nothing is added
    @(posedge sys_clk) intrinsic_cycles <= 6'h04;
    @(posedge sys_clk) phase_in <= 3'h2;
    @(negedge sys_clk); `CHK("phase held", 3'h7, phase_out)
    @(negedge sys_clk); `CHK("phase no wait", 3'h2, phase_out)
    host.wr(6'h0C, 8'h00);
    @(posedge sys_clk) phase_in <= 3'h6;
    @(negedge sys_clk); `CHK("bypass held", 3'h2, phase_out)
    @(negedge sys_clk); `CHK("bypass", 3'h6, phase_out)
  endtask
  // ce low must swallow a write; a later reset brings back the zeros
  task hold_and_reset;
    @(posedge sys_clk) ce <= 1'b0;
    host.wr(6'h0B, 8'h02);
    @(posedge sys_clk) ce <= 1'b1;
    host.rd(6'h0B, v); `CHK("frozen adv", 8'h07, v)
    host.wr(6'h0C, 8'h1A);
    @(posedge sys_clk) reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    reset_values();
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    reset_values();
    adv_levels();
    targets();
    unmapped();
    phase_delay();
    hold_and_reset();
    complete_run();
  end
endmodule // tb
`default_nettype wire
